// ==== hw/melody_pkg.sv ====
// Constants, register map and types for the melody tone sequencer.
// Assumes a 40 MHz system clock and a low-speed time-base tick pulse.
package melody_pkg;

  localparam int  REF_CLK_HZ       = 40_000_000;
  localparam int  LOW_SPEED_HZ     = 32_768;
  localparam int  TICKS_PER_UNIT   = 64;
  localparam int  TEMPO_W          = 4;
  localparam int  LEN_W            = 6;
  localparam int  PITCH_W          = 7;
  localparam int  PHASE_W          = 8;
  localparam int  UNIT_W           = 11;
  localparam int  LCNT_W           = 7;

  // Melody word layout
  localparam int  WORD_LAST_BIT    = 15;
  localparam int  WORD_LEN_HI      = 13;
  localparam int  WORD_LEN_LO      = 8;
  localparam int  WORD_PITCH_HI    = 6;
  localparam int  WORD_PITCH_LO    = 0;
  localparam int  PITCH_SIL_LO     = 2;

  // Phase step per tick: four half-period units per tick give 2*f/(N+2)
  localparam logic [PHASE_W-1:0] PHASE_STEP = 8'h04;
  localparam logic [PHASE_W-1:0] PITCH_BIAS = 8'h02;

  // APB register byte offsets
  localparam logic [7:0] OFS_TEMPO       = 8'h00;
  localparam logic [7:0] OFS_CONTROL     = 8'h04;
  localparam logic [7:0] OFS_START_ADDR  = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK    = 8'h10;

  localparam int  CTRL_START_BIT   = 0;
  localparam int  CTRL_ACTIVE_BIT  = 3;
  localparam int  INT_END_BIT      = 0;

  localparam logic [TEMPO_W-1:0] TEMPO_RST = 4'h0;
  localparam logic               MASK_RST  = 1'b0;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FILL = 2'b01,
    SEQ_PLAY = 2'b10
  } seq_state_t;

endpackage

// ==== hw/melody_tone_sequencer.sv ====
// Melody tone sequencer: fetches melody words from program ROM, plays
// square-wave tones and times notes from the low-speed tick.
// Assumes LOW_SPEED_TICK is a one-cycle pulse synchronous to REF_CLK and
// that the ROM answers each held request with a one-cycle ROM_ACK.
//
// Behaviour
// - Four-bit tempo; codes 0 and 1 equal
// - Word: last flag, length, pitch; bits 14,7 ignored
// - Tone frequency is two ticks over pitch+2
// - Pitch code read as unsigned, bit 6 MSB
// - Pitch bits 6..2 zero means silence
// - Length code bits 13..8, unsigned
// - Zero length behaves as length one
// - Duration is 64 ticks times (tempo+1)(length+1)
// - Tempo bits read as unsigned, bit 3 MSB
// - Start may lengthen the running note slightly
// - Last word raises end interrupt, then stop
// - Start sets active flag; end or reset clears
`timescale 1ns/10ps
module melody_tone_sequencer
  import melody_pkg::*;
#(
  parameter int ROM_AW = 16
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  input  wire logic              LOW_SPEED_TICK,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output logic      [ROM_AW-1:0] ROM_ADDR,
  output logic                   ROM_REQ,
  input  wire logic              ROM_ACK,
  input  wire logic [15:0]       ROM_DATA,
  output logic                   TONE_OUT,
  output logic                   MELODY_ACTIVE,
  output logic                   IRQ
);

  // Longest unit in ticks is not needed in logic; kept for duration math checks
  localparam int UNIT_MAX = TICKS_PER_UNIT * (1 << TEMPO_W);

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFS_TEMPO) || (a == OFS_CONTROL) || (a == OFS_START_ADDR)
           || (a == OFS_INT_STATUS) || (a == OFS_INT_MASK);
  endfunction

  logic [TEMPO_W-1:0] melody_tempo_select_r;
  logic [ROM_AW-1:0]  start_addr_r;
  logic               int_status_r;
  logic               int_mask_r;
  seq_state_t         state_r;
  logic [ROM_AW-1:0]  fetch_addr_r;
  logic               req_r;
  logic               discard_r;
  logic               nxt_vld_r;
  logic [15:0]        nxt_word_r;
  logic               pend_r;
  logic               cur_last_r;
  logic [PITCH_W-1:0] pitch_code_r;
  logic [UNIT_W-1:0]  unit_cnt_r;
  logic [LCNT_W-1:0]  len_cnt_r;
  logic [PHASE_W-1:0] phase_r;
  logic               tone_r;

  logic               wr_en;
  logic               rd_en;
  logic               melody_start_instr;
  logic               playing;
  logic               active;
  logic [TEMPO_W-1:0] tempo_code;
  logic [UNIT_W-1:0]  unit_len;
  logic               unit_wrap;
  logic               expire;
  logic               stop;
  logic               load;
  logic               fetch_ok;
  logic               ack_take;
  logic               end_event;
  logic [LEN_W-1:0]   note_length_code;
  logic [LCNT_W-1:0]  len_load;
  logic [PHASE_W-1:0] phase_sum;
  logic [PHASE_W-1:0] pitch_div;
  logic               silent;

  // APB slave, zero wait states
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && PENABLE && !PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !reg_hit(PADDR);

  assign melody_start_instr = wr_en && (PADDR == OFS_CONTROL) && PWDATA[CTRL_START_BIT];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      melody_tempo_select_r <= TEMPO_RST;
      start_addr_r          <= '0;
      int_mask_r            <= MASK_RST;
    end else if (wr_en) begin
      if (PADDR == OFS_TEMPO) begin
        melody_tempo_select_r <= PWDATA[TEMPO_W-1:0];
      end
      if (PADDR == OFS_START_ADDR) begin
        start_addr_r <= PWDATA[ROM_AW-1:0];
      end
      if (PADDR == OFS_INT_MASK) begin
        int_mask_r <= PWDATA[INT_END_BIT];
      end
    end
  end

  always_comb begin
    PRDATA = '0;
    if (rd_en) begin
      unique case (PADDR)
        OFS_TEMPO:      PRDATA[TEMPO_W-1:0]    = melody_tempo_select_r;
        OFS_CONTROL:    PRDATA[CTRL_ACTIVE_BIT] = active;
        OFS_START_ADDR: PRDATA[ROM_AW-1:0]     = start_addr_r;
        OFS_INT_STATUS: PRDATA[INT_END_BIT]    = int_status_r;
        OFS_INT_MASK:   PRDATA[INT_END_BIT]    = int_mask_r;
        default:        PRDATA = '0;
      endcase
    end
  end

  // Melody-end status: set wins over a write-one clear
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_status_r <= 1'b0;
    end else if (end_event) begin
      int_status_r <= 1'b1;
    end else if (wr_en && (PADDR == OFS_INT_STATUS) && PWDATA[INT_END_BIT]) begin
      int_status_r <= 1'b0;
    end
  end

  assign IRQ = int_status_r && int_mask_r;

  // Duration timing
  assign tempo_code = (melody_tempo_select_r == '0) ? 4'h1 : melody_tempo_select_r;
  assign unit_len   = UNIT_W'(TICKS_PER_UNIT) * (UNIT_W'(tempo_code) + 1'b1);
  // Compare with >= so a tempo lowered mid-note cannot leave the counter past its wrap
  assign unit_wrap  = LOW_SPEED_TICK && (unit_cnt_r >= unit_len - 1'b1);
  assign playing    = (state_r == SEQ_PLAY);
  assign active     = (state_r != SEQ_IDLE);
  assign expire     = playing && unit_wrap && (len_cnt_r == LCNT_W'(1));
  assign stop       = expire && cur_last_r && !pend_r && !melody_start_instr;
  assign load       = nxt_vld_r && active && (!playing || expire) && !stop;
  assign end_event  = load && nxt_word_r[WORD_LAST_BIT];

  assign note_length_code = nxt_word_r[WORD_LEN_HI:WORD_LEN_LO];
  assign len_load = (note_length_code == '0) ? LCNT_W'(1)
                                             : LCNT_W'(note_length_code);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= SEQ_IDLE;
    end else begin
      unique case (state_r)
        SEQ_IDLE: if (melody_start_instr) begin
          state_r <= SEQ_FILL;
        end
        SEQ_FILL: if (load) begin
          state_r <= SEQ_PLAY;
        end
        SEQ_PLAY: begin
          if (stop) begin
            state_r <= SEQ_IDLE;
          end else if (expire && !load) begin
            state_r <= SEQ_FILL;
          end
        end
        default: state_r <= SEQ_IDLE;
      endcase
    end
  end

  // Unit counter restarts on start, which may lengthen the running note
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      unit_cnt_r <= '0;
    end else if (melody_start_instr || load) begin
      unit_cnt_r <= '0;
    end else if (LOW_SPEED_TICK && playing) begin
      unit_cnt_r <= unit_wrap ? '0 : unit_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      len_cnt_r <= '0;
    end else if (load) begin
      len_cnt_r <= len_load + 1'b1;
    end else if (unit_wrap && playing && len_cnt_r != '0) begin
      len_cnt_r <= len_cnt_r - 1'b1;
    end
  end

  // Start pending until the next word is loaded
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_r <= 1'b0;
    end else if (melody_start_instr) begin
      pend_r <= 1'b1;
    end else if (load || stop) begin
      pend_r <= 1'b0;
    end
  end

  // ROM prefetch
  assign fetch_ok = active && !req_r && !nxt_vld_r && !(playing && cur_last_r && !pend_r);
  assign ack_take = req_r && ROM_ACK && !discard_r && !melody_start_instr;
  assign ROM_REQ  = req_r;
  assign ROM_ADDR = fetch_addr_r;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_r <= 1'b0;
    end else if (req_r && ROM_ACK) begin
      req_r <= 1'b0;
    end else if (fetch_ok) begin
      req_r <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      discard_r <= 1'b0;
    end else if (melody_start_instr) begin
      discard_r <= req_r && !ROM_ACK;
    end else if (ROM_ACK) begin
      discard_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fetch_addr_r <= '0;
    end else if (melody_start_instr && !(req_r && !ROM_ACK)) begin
      fetch_addr_r <= start_addr_r;
    end else if (discard_r && ROM_ACK) begin
      fetch_addr_r <= start_addr_r; // Address held until the dropped word is acked
    end else if (ack_take) begin
      fetch_addr_r <= fetch_addr_r + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      nxt_vld_r  <= 1'b0;
      nxt_word_r <= '0;
    end else if (melody_start_instr) begin
      nxt_vld_r <= 1'b0;
    end else if (ack_take) begin
      nxt_vld_r  <= 1'b1;
      nxt_word_r <= ROM_DATA;
    end else if (load) begin
      nxt_vld_r <= 1'b0;
    end
  end

  // Current note; bits 14 and 7 are never looked at
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur_last_r   <= 1'b0;
      pitch_code_r <= '0;
    end else if (load) begin
      cur_last_r   <= nxt_word_r[WORD_LAST_BIT];
      pitch_code_r <= nxt_word_r[WORD_PITCH_HI:WORD_PITCH_LO];
    end
  end

  // Tone generator: phase accumulator toggles the output 4f/(N+2) times a second
  assign silent    = (pitch_code_r[PITCH_W-1:PITCH_SIL_LO] == '0);
  assign pitch_div = PHASE_W'(pitch_code_r) + PITCH_BIAS;
  assign phase_sum = phase_r + PHASE_STEP;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_r <= '0;
      tone_r  <= 1'b0;
    end else if (load || !playing || silent) begin
      phase_r <= '0;
      tone_r  <= 1'b0;
    end else if (LOW_SPEED_TICK) begin
      if (phase_sum >= pitch_div) begin
        phase_r <= phase_sum - pitch_div;
        tone_r  <= !tone_r;
      end else begin
        phase_r <= phase_sum;
      end
    end
  end

  assign TONE_OUT      = tone_r;
  assign MELODY_ACTIVE = active;

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_start_sets_active: assert property (
    melody_start_instr && !active |=> active)
    else $error("start did not set active flag");

  a_stop_clears_active: assert property (
    stop |=> !active && !ROM_REQ)
    else $error("last note end did not stop melody");

  a_end_irq_set: assert property (
    end_event |=> int_status_r)
    else $error("last word did not raise end status");

  a_silence_output: assert property (
    playing && silent |=> !TONE_OUT)
    else $error("tone output during silence code");

  a_len_reload: assert property (
    load && (nxt_word_r[WORD_LEN_HI:WORD_LEN_LO] == '0) |=> len_cnt_r == LCNT_W'(2))
    else $error("zero length not treated as one");

  a_len_value: assert property (
    load |=> len_cnt_r == $past(len_load) + 1'b1)
    else $error("length count not loaded from word");

  a_tempo_equal: assert property (
    melody_tempo_select_r == 4'h0 |-> unit_len == UNIT_W'(2 * TICKS_PER_UNIT))
    else $error("tempo code zero differs from one");

  a_unit_width: assert property (
    melody_tempo_select_r != '0 |-> unit_len <= UNIT_W'(UNIT_MAX) && unit_len ==
      (UNIT_W'(melody_tempo_select_r) << $clog2(TICKS_PER_UNIT)) + UNIT_W'(TICKS_PER_UNIT))
    else $error("tempo bits not weighted as unsigned value");

  a_no_gap_load: assert property (
    expire && nxt_vld_r && !stop |=> playing
      && pitch_code_r == $past(nxt_word_r[WORD_PITCH_HI:WORD_PITCH_LO]))
    else $error("prefetched word not loaded at note end");

  a_tone_toggle: assert property (
    playing && !silent && !load && LOW_SPEED_TICK && (phase_sum >= pitch_div)
      |=> TONE_OUT != $past(TONE_OUT))
    else $error("tone did not toggle on phase wrap");

  a_start_unit_clr: assert property (
    melody_start_instr |=> unit_cnt_r == '0)
    else $error("start did not realign note timing");

  c_melody_end:   cover property (end_event ##[1:1000] stop);
  c_chain_start:  cover property (cur_last_r && pend_r && load);
  c_silent_note:  cover property (load ##1 (playing && silent));
  c_refill_gap:   cover property (expire && !load && !stop);

endmodule

// ==== sim/melody_rom_model.sv ====
// Program ROM model holding melody words for the tone sequencer.
// Assumes one outstanding request, held until the one-cycle ack.
`timescale 1ns/10ps
module melody_rom_model #(
  parameter int LAG = 3
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] addr,
  input  wire logic        req,
  output logic             ack,
  output logic      [15:0] data
);
  logic [15:0] mem [0:15];
  int          wait_cnt;

  // Data is valid only with ack; otherwise it flips every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack      <= 1'b0;
      data     <= 16'h0000;
      wait_cnt <= 0;
    end else if (req && !ack && wait_cnt == LAG) begin
      ack      <= 1'b1;
      data     <= mem[addr[3:0]];
      wait_cnt <= 0;
    end else begin
      ack      <= 1'b0;
      data     <= ~data;
      wait_cnt <= (req && !ack) ? wait_cnt + 1 : 0;
    end
  end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the melody tone sequencer.
// Assumes the ROM model answers requests; the tick runs every 4 clocks.
`timescale 1ns/10ps
module tb_top;
  import melody_pkg::*;
  logic        REF_CLK, RST_N, LOW_SPEED_TICK, PSEL, PENABLE, PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        PREADY, PSLVERR, ROM_REQ, ROM_ACK, TONE_OUT, MELODY_ACTIVE, IRQ;
  logic [15:0] ROM_ADDR, ROM_DATA;
  logic        tone_q, err;
  int          n_mismatch, n_compared, n_tick, n_tog, tick_div, t0, g0;

  melody_tone_sequencer u_melody_tone_sequencer (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .LOW_SPEED_TICK(LOW_SPEED_TICK),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ROM_ADDR(ROM_ADDR), .ROM_REQ(ROM_REQ), .ROM_ACK(ROM_ACK),
    .ROM_DATA(ROM_DATA), .TONE_OUT(TONE_OUT), .MELODY_ACTIVE(MELODY_ACTIVE),
    .IRQ(IRQ));

  melody_rom_model u_melody_rom_model (
    .clk(REF_CLK), .rst_n(RST_N), .addr(ROM_ADDR), .req(ROM_REQ),
    .ack(ROM_ACK), .data(ROM_DATA));

  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end

  // Tick source plus counters of ticks and tone edges
  always @(posedge REF_CLK) begin
    tick_div       <= (tick_div == 3) ? 0 : tick_div + 1;
    LOW_SPEED_TICK <= (tick_div == 3);
    if (LOW_SPEED_TICK) n_tick <= n_tick + 1;
    tone_q <= TONE_OUT;
    if (TONE_OUT !== tone_q) n_tog <= n_tog + 1;
  end

  task automatic complete_run();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge REF_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge REF_CLK);
      if (PREADY === 1'b1) break;
    end
    rd  = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (i == 50) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  // Waits for the interrupt, or for the end of the melody
  task automatic wait_ev(input bit fall_act);
    int i;
    for (i = 0; i < 20000; i++) begin
      @(posedge REF_CLK);
      if (fall_act ? (MELODY_ACTIVE === 1'b0) : (IRQ === 1'b1)) break;
    end
    if (i == 20000) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic t_regs();
    apb(1'b0, OFS_TEMPO, 32'h0);
    chk_val(rd, {28'h0, TEMPO_RST});
    apb(1'b0, OFS_INT_MASK, 32'h0);
    chk_val(rd, {31'h0, MASK_RST});
    apb(1'b1, OFS_TEMPO, 32'hF);
    apb(1'b0, OFS_TEMPO, 32'h0);
    chk_val(rd, 32'hF);
    apb(1'b1, OFS_START_ADDR, 32'h4);
    apb(1'b0, OFS_START_ADDR, 32'h0);
    chk_val(rd, 32'h4);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk_val({31'h0, err}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk_val(rd, 32'h0);
    chk_val({31'h0, err}, 32'h1);
  endtask

  // Tone then silent last word; tempo 2 gives 384 ticks per note
  task automatic t_melody();
    apb(1'b1, OFS_TEMPO, 32'h2);
    apb(1'b1, OFS_START_ADDR, 32'h4);
    apb(1'b1, OFS_INT_MASK, 32'h1);
    t0 = n_tick;
    g0 = n_tog;
    apb(1'b1, OFS_CONTROL, 32'h1);
    apb(1'b0, OFS_CONTROL, 32'h0);
    chk_val({31'h0, rd[CTRL_ACTIVE_BIT]}, 32'h1);
    wait_ev(1'b0);
    chk_rng(n_tick - t0, 383, 388);
    chk_rng(n_tog - g0, 35, 37);
    t0 = n_tick;
    g0 = n_tog;
    wait_ev(1'b1);
    chk_rng(n_tick - t0, 382, 386);
    chk_rng(n_tog - g0, 0, 1);
    chk_val({31'h0, TONE_OUT}, 32'h0);
    apb(1'b0, OFS_CONTROL, 32'h0);
    chk_val({31'h0, rd[CTRL_ACTIVE_BIT]}, 32'h0);
    chk_val({16'h0, ROM_ADDR}, 32'h6);
    chk_val({31'h0, ROM_REQ}, 32'h0);
  endtask

  task automatic t_irq();
    chk_val({31'h0, IRQ}, 32'h1);
    apb(1'b0, OFS_INT_STATUS, 32'h0);
    chk_val(rd, 32'h1);
    apb(1'b1, OFS_INT_MASK, 32'h0);
    @(negedge REF_CLK);
    chk_val({31'h0, IRQ}, 32'h0);
    apb(1'b1, OFS_INT_MASK, 32'h1);
    @(negedge REF_CLK);
    chk_val({31'h0, IRQ}, 32'h1);
    apb(1'b1, OFS_INT_STATUS, 32'h1);
    @(negedge REF_CLK);
    chk_val({31'h0, IRQ}, 32'h0);
    apb(1'b0, OFS_INT_STATUS, 32'h0);
    chk_val(rd, 32'h0);
  endtask

  // Tempo code zero plays like code one: 256 ticks for the first note
  task automatic t_tempo0();
    apb(1'b1, OFS_TEMPO, 32'h0);
    t0 = n_tick;
    apb(1'b1, OFS_CONTROL, 32'h1);
    wait_ev(1'b0);
    chk_rng(n_tick - t0, 255, 260);
    wait_ev(1'b1);
    chk_val({16'h0, ROM_ADDR}, 32'h6);
    apb(1'b1, OFS_INT_STATUS, 32'h1);
  endtask

  initial begin
    RST_N = 1'b0;
    LOW_SPEED_TICK = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    tone_q = 1'b0;
    {n_mismatch, n_compared, n_tick, n_tog, tick_div} = '0;
    // Bits 14 and 7 set in the tone word must not matter
    u_melody_rom_model.mem[4] = 16'h41A8;
    u_melody_rom_model.mem[5] = 16'h8003;
    repeat (6) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(negedge REF_CLK);
    chk_val({31'h0, MELODY_ACTIVE}, 32'h0);
    t_regs();
    t_melody();
    t_irq();
    t_tempo0();
    complete_run();
  end
endmodule
